//--- sef_defs.svh
// Constants of the serial memory slave front end: timing, codes, widths.
// Assumes the block clock runs at the rate given by SEF_CLK_NS.
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH

// Block clock period
`define SEF_CLK_NS       10
// Longest noise pulse swallowed on clock and data inputs
`define SEF_GLITCH_NS    100
`define SEF_FILT_CYC     ((`SEF_GLITCH_NS + `SEF_CLK_NS - 1) / `SEF_CLK_NS)
// Power-up to ready delay
`define SEF_PU_MS        1
`define SEF_PU_CYC       ((`SEF_PU_MS * 1000000) / `SEF_CLK_NS)
`define SEF_PU_W         20
`define SEF_FILT_W       4
// Fixed device type code in the upper nibble of the slave address
`define SEF_TYPE_CODE    4'hA
// Index of the first data byte after the two memory address bytes
`define SEF_DATA_IDX     2'h2

`endif

//--- sef_pkg.sv
// Types of the serial memory slave front end.
// Assumes sef_defs.svh is visible to every file that uses this package.
`include "sef_defs.svh"

package sef_pkg;

	typedef enum logic [2:0] {
		SEF_IDLE,
		SEF_ADDR,
		SEF_RX,
		SEF_ACK_OUT,
		SEF_TX,
		SEF_ACK_IN
	} sef_state_e;

	typedef struct packed {
		sef_state_e              state;
		logic [5:0]              sync1;
		logic [5:0]              sync2;
		logic                    scl_f;
		logic                    sda_f;
		logic [`SEF_FILT_W-1:0]  scl_cnt;
		logic [`SEF_FILT_W-1:0]  sda_cnt;
		logic [`SEF_PU_W-1:0]    pu_cnt;
		logic                    ready;
		logic [7:0]              shreg;
		logic [2:0]              bitcnt;
		logic [1:0]              idx;
		logic                    rw;
		logic                    wp_lat;
		logic                    ack_in;
		logic                    sda_oe;
		logic [7:0]              rx_byte;
		logic                    rx_valid;
		logic [1:0]              rx_index;
		logic                    tx_take;
		logic                    start_p;
		logic                    stop_p;
		logic                    wp_reject;
		logic                    selected;
		logic                    byte_done;
		logic                    nack;
	} sef_regs_s;

endpackage

//--- sef_front.sv
// Slave front end of a two-wire serial memory: pin sampling, glitch
// filtering, start/stop, address match, acknowledge, byte shifting.
// Assumes the bus pull-up and pad pull-downs sit outside; memory array
// and write cycle timer sit on the user side.
`timescale 1ns/1ps
`default_nettype none
`include "sef_defs.svh"

module sef_front #(
	parameter int unsigned PU_CYCLES = `SEF_PU_CYC
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        device_select_bit0,
	input  wire logic        device_select_bit1,
	input  wire logic        device_select_bit2,
	input  wire logic        write_protect,
	input  wire logic        write_busy,
	input  wire logic [7:0]  tx_data,
	output logic             tx_take,
	output logic [7:0]       rx_byte,
	output logic             rx_valid,
	output logic [1:0]       rx_index,
	output logic             rd_mode,
	output logic             selected,
	output logic             start_seen,
	output logic             stop_seen,
	output logic             wp_reject,
	output logic             not_acknowledged,
	output logic             ready
);

	localparam logic [`SEF_FILT_W-1:0] FILT = `SEF_FILT_W'(`SEF_FILT_CYC);
	localparam logic [`SEF_PU_W-1:0]   PU_END = `SEF_PU_W'(PU_CYCLES);

	sef_pkg::sef_regs_s r;
	sef_pkg::sef_regs_s n;

	// --------------------------------------------------------------
	// Glitch filter: a level must differ for FILT+1 samples to pass
	// --------------------------------------------------------------
	function automatic logic [`SEF_FILT_W:0] filt(
		input logic                   lvl,
		input logic                   raw,
		input logic [`SEF_FILT_W-1:0] cnt
	);
		logic [`SEF_FILT_W:0] res;
		if (raw == lvl) begin
			res = {lvl, {`SEF_FILT_W{1'b0}}};
		end else if (cnt == FILT) begin
			res = {raw, {`SEF_FILT_W{1'b0}}};
		end else begin
			res = {lvl, cnt + `SEF_FILT_W'(1)};
		end
		return res;
	endfunction

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic addr_hit;

	always_comb begin
		n = r;
		n.rx_valid  = 1'b0;
		n.tx_take   = 1'b0;
		n.start_p   = 1'b0;
		n.stop_p    = 1'b0;
		n.wp_reject = 1'b0;

		// Pins cross into mclk; pad pull-downs make open pins read low
		n.sync1 = {scl, sda_in, write_protect, device_select_bit2,
			device_select_bit1, device_select_bit0};
		n.sync2 = r.sync1;
		{n.scl_f, n.scl_cnt} = filt(r.scl_f, r.sync2[5], r.scl_cnt);
		{n.sda_f, n.sda_cnt} = filt(r.sda_f, r.sync2[4], r.sda_cnt);

		// Serial clock is only sampled, never driven
		scl_rise = n.scl_f & ~r.scl_f;
		scl_fall = ~n.scl_f & r.scl_f;
		start_c  = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
		stop_c   = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
		addr_hit = (r.shreg[7:4] == `SEF_TYPE_CODE) &&
			(r.shreg[3:1] == r.sync2[2:0]);

		if (!r.ready) begin
			// Commands are ignored until the power-up delay expires
			n.state  = sef_pkg::SEF_IDLE;
			n.sda_oe = 1'b0;
			n.pu_cnt = r.pu_cnt + `SEF_PU_W'(1);
			n.ready  = (n.pu_cnt >= PU_END);
		end else if (start_c) begin
			// Repeated start is legal anywhere and restarts addressing
			n.state    = sef_pkg::SEF_ADDR;
			n.bitcnt   = 3'h0;
			n.idx      = 2'h0;
			n.sda_oe   = 1'b0;
			n.selected = 1'b0;
			n.start_p  = 1'b1;
			n.byte_done = 1'b0;
			n.nack      = 1'b0;
		end else if (stop_c) begin
			n.state    = sef_pkg::SEF_IDLE;
			n.sda_oe   = 1'b0;
			n.selected = 1'b0;
			n.stop_p   = 1'b1;
			n.byte_done = 1'b0;
			n.nack      = 1'b0;
		end else begin
			case (r.state)
				sef_pkg::SEF_IDLE: begin
					n.sda_oe = 1'b0;
				end
				sef_pkg::SEF_ADDR, sef_pkg::SEF_RX: begin
					if (scl_rise) begin
						n.shreg  = {r.shreg[6:0], r.sda_f};
						n.bitcnt = r.bitcnt + 3'h1;
						if (r.bitcnt == 3'h7) begin
							n.rx_byte  = {r.shreg[6:0], r.sda_f};
							n.rx_index = r.idx;
							n.rx_valid = (r.state == sef_pkg::SEF_RX);
							n.byte_done = 1'b1;
						end
					end else if (scl_fall && r.byte_done) begin
						// Eight bits in: decide acknowledge on the ninth clock.
						// The fall that closes a start has no bits behind it.
						n.byte_done = 1'b0;
						if (r.state == sef_pkg::SEF_ADDR) begin
							if (addr_hit && !write_busy) begin
								n.state    = sef_pkg::SEF_ACK_OUT;
								n.sda_oe   = 1'b1;
								n.rw       = r.shreg[0];
								n.selected = 1'b1;
							end else begin
								n.state = sef_pkg::SEF_IDLE;
							end
						end else if (r.idx == `SEF_DATA_IDX && r.wp_lat) begin
							n.state     = sef_pkg::SEF_IDLE;
							n.wp_reject = 1'b1;
						end else begin
							n.state  = sef_pkg::SEF_ACK_OUT;
							n.sda_oe = 1'b1;
							// Index saturates on the data bytes
							if (r.idx != `SEF_DATA_IDX) begin
								n.idx = r.idx + 2'h1;
							end
						end
					end
				end
				sef_pkg::SEF_ACK_OUT: begin
					if (scl_fall) begin
						n.sda_oe = 1'b0;
						n.bitcnt = 3'h0;
						// Protect level strobed on the fall that ends each slave acknowledge
						n.wp_lat = r.sync2[3];
						if (r.rw) begin
							n.state   = sef_pkg::SEF_TX;
							n.shreg   = tx_data;
							n.tx_take = 1'b1;
							n.sda_oe  = ~tx_data[7];
						end else begin
							n.state = sef_pkg::SEF_RX;
						end
					end
				end
				sef_pkg::SEF_TX: begin
					if (scl_fall) begin
						if (r.bitcnt == 3'h7) begin
							n.state  = sef_pkg::SEF_ACK_IN;
							n.sda_oe = 1'b0;
						end else begin
							n.bitcnt = r.bitcnt + 3'h1;
							n.shreg  = {r.shreg[6:0], 1'b0};
							// Only low is driven; a one is a release
							n.sda_oe = ~r.shreg[6];
						end
					end
				end
				sef_pkg::SEF_ACK_IN: begin
					if (scl_rise) begin
						n.ack_in = ~r.sda_f;
					end else if (scl_fall) begin
						n.bitcnt = 3'h0;
						if (r.ack_in) begin
							n.state   = sef_pkg::SEF_TX;
							n.shreg   = tx_data;
							n.tx_take = 1'b1;
							n.sda_oe  = ~tx_data[7];
						end else begin
							// Master declined: wait for stop, line released
							n.state = sef_pkg::SEF_IDLE;
							n.nack  = 1'b1;
						end
					end
				end
				default: begin
					n.state = sef_pkg::SEF_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// State register; resetn is the power-on reset
	// --------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r       <= '0;
			r.scl_f <= 1'b1;
			r.sda_f <= 1'b1;
			r.sync1 <= 6'h30;
			r.sync2 <= 6'h30;
			r.state <= sef_pkg::SEF_IDLE;
		end else if (ce) begin
			r <= n;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign sda_out          = 1'b0;
	assign sda_oe           = r.sda_oe;
	assign tx_take          = r.tx_take;
	assign rx_byte          = r.rx_byte;
	assign rx_valid         = r.rx_valid;
	assign rx_index         = r.rx_index;
	assign rd_mode          = r.rw;
	assign selected         = r.selected;
	assign start_seen       = r.start_p;
	assign stop_seen        = r.stop_p;
	assign wp_reject        = r.wp_reject;
	assign not_acknowledged = r.nack;
	assign ready            = r.ready;

endmodule
`default_nettype wire

//--- sef_front_monitor.sv
// Checker of the slave front end, watching top-level ports only.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sef_front_monitor (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic write_busy,
	input wire logic tx_take,
	input wire logic rx_valid,
	input wire logic rd_mode,
	input wire logic selected,
	input wire logic start_seen,
	input wire logic stop_seen,
	input wire logic wp_reject,
	input wire logic ready
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	quiet_unready_a: assert property (!ready |-> !sda_oe && !selected)
		else $error("bus activity before ready");
	ready_hold_a: assert property (ready |=> ready)
		else $error("ready dropped without reset");
	// Glitch filter spaces output changes by more than 8 cycles
	oe_steady_a: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*8])
		else $error("data output changed too soon");
	rx_released_a: assert property (rx_valid |-> !sda_oe)
		else $error("data line held while receiving");
	wp_decline_a: assert property (wp_reject |=> !sda_oe [*8])
		else $error("protected byte acknowledged");
	busy_not_acknowledged_a: assert property ($rose(selected) |-> !$past(write_busy))
		else $error("acknowledged during write cycle");
	take_read_a: assert property (tx_take |-> rd_mode && selected)
		else $error("byte loaded outside a read");
	frame_drop_a: assert property ((start_seen || stop_seen) |-> ##[0:1] !selected)
		else $error("still selected after start or stop");
	sel_ack_a: assert property ($rose(selected) |-> ##[0:1] sda_oe)
		else $error("selection without acknowledge");
	cover property (rx_valid);
	cover property (wp_reject);
	cover property (tx_take);
endmodule
bind sef_front sef_front_monitor u_mon (.mclk, .resetn, .sda_out, .sda_oe,
	.write_busy, .tx_take, .rx_valid, .rd_mode, .selected, .start_seen,
	.stop_seen, .wp_reject, .ready);
`default_nettype wire

//--- sef_master_model.sv
// Behavioural two-wire bus master: drives the serial clock, pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module sef_master_model #(
	parameter int H = 25
) (
	input  wire logic mclk,
	input  wire logic sda,
	output var logic  scl,
	output var logic  oe
);
	initial begin
		scl = 1'b1;
		oe = 1'b0;
	end
	// Half period kept well above the filter span
	task step(input logic c, input logic d);
		@(posedge mclk);
		scl <= c;
		oe <= !d;
		repeat (H) @(posedge mclk);
	endtask
	task start;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task stop;
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		repeat (470) @(posedge mclk);
	endtask
	task xfer(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ak);
		logic [8:0] v;
		logic [8:0] r;
		v = {d, mack};
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, v[i]);
			step(1'b1, v[i]);
			r[i] = sda;
			step(1'b0, v[i]);
		end
		q = r[8:1];
		ak = r[0];
	endtask
endmodule
`default_nettype wire

//--- test_serial_eeprom_bus_slave_front.sv
// Bench of the slave front end against the behavioural bus master.
// Assumes the pull-up sits here: the wire is low while anyone pulls it.
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_bus_slave_front;
	logic       mclk = 1'b0, resetn = 1'b0, wp = 1'b0, busy = 1'b0;
	logic [2:0] sel = 3'h5;
	logic [7:0] txd = 8'hC3, rxb, q, last = 8'h00;
	logic [1:0] rxi, li = 2'h0;
	logic       scl, m_oe, d_oe, take, rxv, rdm, seld, wprs = 1'b0, ack;
	logic       wprs_p, rdy, ce = 1'b1, nak, sta, sto;
	int         errors = 0, checks = 0, cyc = 0, starts = 0, stops = 0;
	wire        sda = !(m_oe || d_oe);
	always #5 mclk = ~mclk;
	sef_master_model m (.mclk(mclk), .sda(sda), .scl(scl), .oe(m_oe));
	sef_front #(.PU_CYCLES(50)) DUT (.mclk(mclk), .resetn(resetn),
		.ce(ce), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(d_oe),
		.device_select_bit0(sel[0]), .device_select_bit1(sel[1]),
		.device_select_bit2(sel[2]), .write_protect(wp),
		.write_busy(busy), .tx_data(txd), .tx_take(take), .rx_byte(rxb),
		.rx_valid(rxv), .rx_index(rxi), .rd_mode(rdm), .selected(seld),
		.start_seen(sta), .stop_seen(sto), .wp_reject(wprs_p),
		.not_acknowledged(nak), .ready(rdy));
	always @(posedge mclk) begin
		cyc++;
		if (sta) starts++;
		if (sto) stops++;
		if (rxv) {last, li} <= {rxb, rxi};
		if (wprs_p) wprs <= 1'b1;
		if (take) txd <= txd + 8'h11;
		if (cyc == 60000) begin
			errors++;
			finish_test();
		end
	end
	task chk(input string n, input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task finish_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task addr(input logic [7:0] a);
		m.start();
		m.xfer(a, 1'b1, q, ack);
	endtask
	task t_reset;
		repeat (2) @(posedge mclk);
		chk("ready", {7'h0, rdy}, 8'h00);
		resetn <= 1'b1;
		// Enable low must hold the power-up count still
		ce <= 1'b0;
		repeat (20) @(posedge mclk);
		ce <= 1'b1;
		repeat (45) @(posedge mclk);
		chk("ready", {7'h0, rdy}, 8'h00);
		repeat (10) @(posedge mclk);
		chk("ready", {7'h0, rdy}, 8'h01);
	endtask
	task t_write;
		addr({4'hA, sel, 1'b0});
		chk("addr ack", {7'h0, ack}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m.xfer(8'h96 + i, 1'b1, q, ack);
			chk("byte ack", {7'h0, ack}, 8'h00);
			chk("rx byte", last, 8'h96 + i);
			chk("rx idx", {6'h0, li}, (i > 2) ? 8'h02 : i);
		end
		m.stop();
		chk("starts", starts, 8'h01);
		chk("stops", stops, 8'h01);
	endtask
	task t_reject;
		for (int k = 0; k < 4; k++) begin
			addr(k < 3 ? {4'hA, sel ^ (3'h1 << k), 1'b0} : {4'hB, sel, 1'b0});
			chk("bad addr", {7'h0, ack}, 8'h01);
			m.stop();
		end
		busy <= 1'b1;
		addr({4'hA, sel, 1'b0});
		chk("busy ack", {7'h0, ack}, 8'h01);
		m.stop();
		busy <= 1'b0;
	endtask
	task t_wp;
		wp <= 1'b1;
		addr({4'hA, sel, 1'b0});
		m.xfer(8'h01, 1'b1, q, ack);
		m.xfer(8'h02, 1'b1, q, ack);
		m.xfer(8'h5A, 1'b1, q, ack);
		chk("wp ack", {7'h0, ack}, 8'h01);
		chk("wp flag", {7'h0, wprs}, 8'h01);
		m.stop();
		wp <= 1'b0;
	endtask
	task t_read;
		addr({4'hA, sel, 1'b1});
		chk("rd ack", {7'h0, ack}, 8'h00);
		chk("rd mode", {7'h0, rdm}, 8'h01);
		m.xfer(8'hFF, 1'b0, q, ack);
		chk("rd byte0", q, 8'hC3);
		chk("nack", {7'h0, nak}, 8'h00);
		m.xfer(8'hFF, 1'b1, q, ack);
		chk("rd byte1", q, 8'hD4);
		chk("nack", {7'h0, nak}, 8'h01);
		m.stop();
		chk("nack", {7'h0, nak}, 8'h00);
	endtask
	initial begin
		t_reset();
		t_write();
		t_reject();
		t_wp();
		t_read();
		finish_test();
	end
endmodule
`default_nettype wire
